// file: logic/sfr_pkg.sv
package sfr_pkg;

  // ----------------------------------------------------------------
  // Read opcodes
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_FAST_READ = 8'h0B;
  localparam logic [7:0] OP_SLOW_READ = 8'h03;
  localparam logic [7:0] OP_LOWP_READ = 8'h01;
  localparam logic [7:0] OP_PAGE_READ = 8'hD2;
  localparam logic [7:0] OP_BUF1_FAST = 8'hD4;
  localparam logic [7:0] OP_BUF1_SLOW = 8'hD1;
  localparam logic [7:0] OP_BUF2_FAST = 8'hD6;
  localparam logic [7:0] OP_BUF2_SLOW = 8'hD3;

  // ----------------------------------------------------------------
  // Dummy byte counts per command family
  // ----------------------------------------------------------------
  localparam logic [2:0] DUMMY_NONE = 3'h0;
  localparam logic [2:0] DUMMY_ONE = 3'h1;
  localparam logic [2:0] DUMMY_FOUR = 3'h4;

  // ----------------------------------------------------------------
  // Address layout
  // ----------------------------------------------------------------
  localparam int PAGE_W = 15;
  localparam int BYTE_W = 9;
  localparam logic [1:0] ADDR_LAST_BYTE = 2'h2;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [8:0] LAST_BYTE_264 = 9'h107;
  localparam logic [8:0] LAST_BYTE_256 = 9'h0FF;
  localparam logic [14:0] PAGE_STEP = 15'h0001;
  localparam logic [8:0] BYTE_STEP = 9'h001;

  // ----------------------------------------------------------------
  // Pin synchroniser reset: chip select idles high
  // ----------------------------------------------------------------
  localparam logic [3:0] SYNC_RST = 4'h1;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_OPCODE,
    ST_ADDR,
    ST_DUMMY,
    ST_DATA,
    ST_IGNORE
  } sfr_state_t;

  typedef enum logic [1:0] {
    KIND_ARRAY,
    KIND_PAGE,
    KIND_BUFFER
  } sfr_kind_t;

  typedef enum logic [1:0] {
    SRC_ARRAY,
    SRC_BUF1,
    SRC_BUF2
  } sfr_src_t;

endpackage

// file: logic/sfr_pin_sync.sv
`timescale 1ns/1ps
module sfr_pin_sync
(
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_reset_n,
  // Raw pins {page_256, si, sck, cs_n}
  input wire logic [3:0] i_pins,
  // Synchronised levels and clock edges
  output logic [3:0] o_pins,
  output logic o_sck_rise,
  output logic o_sck_fall
);

  typedef struct packed {
    logic [3:0] meta;
    logic [3:0] sync;
    logic sck_prev;
  } sfr_sync_regs_t;

  sfr_sync_regs_t s_r;
  sfr_sync_regs_t s_nxt;

  // ----------------------------------------------------------------
  // Two-flop synchroniser; edges are found past the second stage only
  // ----------------------------------------------------------------
  always_comb
  begin
    s_nxt.meta = i_pins;
    s_nxt.sync = s_r.meta; // Only the second stage reads the first
    s_nxt.sck_prev = s_r.sync[1];
  end

  // Select resets to its idle high level so no false command starts
  always_ff @(posedge i_mclk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      s_r.meta <= sfr_pkg::SYNC_RST;
      s_r.sync <= sfr_pkg::SYNC_RST;
      s_r.sck_prev <= 1'b0;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  // Edge pulses last one clock
  assign o_pins = s_r.sync;
  assign o_sck_rise = s_r.sync[1] & ~s_r.sck_prev;
  assign o_sck_fall = ~s_r.sync[1] & s_r.sck_prev;

endmodule

// file: logic/sfr_read_ctrl.sv
// Function
// - 0Bh: three address, one dummy, data
// - 264 mode: 15 page bits, 9 byte
// - 256 mode: bits 22-8 page, 7-0 byte
// - Array read crosses into next page seamlessly
// - Array read wraps from end to start
// - Chip select high ends read, output off
// - Array reads bypass and preserve both buffers
// - 03h: three address bytes, no dummy
// - 01h: three address bytes, no dummy
// - D2h: three address, four dummy bytes
// - Page read wraps within same page
// - D4h/D1h buffer 1, D6h/D3h buffer 2
// - Buffer address: offset 9 or 8 bits
// - D4h/D6h one dummy; D1h/D3h none
// - Buffer read wraps to buffer start
// - Everything travels most significant bit first
`timescale 1ns/1ps
module sfr_read_ctrl
(
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_reset_n,
  // Serial pins, asynchronous to i_mclk
  input wire logic i_cs_n,
  input wire logic i_sck,
  input wire logic i_si,
  output logic o_so,
  output logic o_so_oe,
  // Page size strap: 1 selects 256-byte pages
  input wire logic i_page_256,
  // Storage read port, data valid one clock after address
  output logic o_mem_rd,
  output sfr_pkg::sfr_src_t o_mem_src,
  output logic [14:0] o_mem_page,
  output logic [8:0] o_mem_byte,
  input wire logic [7:0] i_mem_data
);

  typedef struct packed {
    sfr_pkg::sfr_state_t state;
    sfr_pkg::sfr_kind_t kind;
    sfr_pkg::sfr_src_t src;
    logic p256;
    logic [2:0] dummy;
    logic [2:0] in_cnt;
    logic [2:0] byte_idx;
    logic [7:0] shift_in;
    logic [15:0] addr_hi;
    logic [14:0] page;
    logic [8:0] byte_pos;
    logic [2:0] out_cnt;
    logic [7:0] shift_out;
    logic so;
    logic oe;
    logic rd;
  } sfr_regs_t;

  sfr_regs_t s_r;
  sfr_regs_t s_nxt;
  logic [3:0] pins;
  logic sck_rise;
  logic sck_fall;
  logic cs_low;
  logic si;

  // ----------------------------------------------------------------
  // Pin synchronisation
  // ----------------------------------------------------------------
  sfr_pin_sync u_sync
  (
    .i_mclk(i_mclk),
    .i_reset_n(i_reset_n),
    .i_pins({i_page_256, i_si, i_sck, i_cs_n}),
    .o_pins(pins),
    .o_sck_rise(sck_rise),
    .o_sck_fall(sck_fall)
  );

  assign cs_low = ~pins[0];
  assign si = pins[2];

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------

  // Last byte of a page or buffer for the latched page size
  function automatic logic [8:0] last_byte(input logic p256);
    last_byte = p256 ? sfr_pkg::LAST_BYTE_256 : sfr_pkg::LAST_BYTE_264;
  endfunction

  // Start byte from the 24 address bits; page bits ignored for buffers
  function automatic logic [8:0] start_byte(input logic p256, input logic [23:0] a);
    start_byte = p256 ? {1'b0, a[7:0]} : a[8:0];
  endfunction

  // Page index from the 24 address bits
  function automatic logic [14:0] start_page(input logic p256, input logic [23:0] a);
    start_page = p256 ? a[22:8] : a[23:9];
  endfunction

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    logic [7:0] full;
    logic [23:0] addr;
    full = {s_r.shift_in[6:0], si};
    addr = {s_r.addr_hi, full};
    s_nxt = s_r;
    if (!cs_low)
    begin
      // Select high at any time aborts and floats the output
      s_nxt.state = sfr_pkg::ST_IDLE;
      s_nxt.oe = 1'b0;
      s_nxt.so = 1'b0;
      s_nxt.rd = 1'b0;
      s_nxt.in_cnt = 3'h0;
    end
    else
    begin
      case (s_r.state)
        sfr_pkg::ST_IDLE:
        begin
          // Page size caught at select fall and held to the end
          s_nxt.p256 = pins[3];
          s_nxt.state = sfr_pkg::ST_OPCODE;
          s_nxt.in_cnt = 3'h0;
          s_nxt.byte_idx = 3'h0;
        end
        sfr_pkg::ST_OPCODE, sfr_pkg::ST_ADDR, sfr_pkg::ST_DUMMY:
        begin
          if (sck_rise)
          begin
            s_nxt.shift_in = full;
            s_nxt.in_cnt = s_r.in_cnt + 3'h1;
            if (s_r.in_cnt == sfr_pkg::BIT_LAST)
            begin
              s_nxt.byte_idx = s_r.byte_idx + 3'h1;
              if (s_r.state == sfr_pkg::ST_OPCODE)
              begin
                s_nxt.state = sfr_pkg::ST_ADDR;
                s_nxt.byte_idx = 3'h0;
                case (full)
                  sfr_pkg::OP_FAST_READ:
                  begin
                    s_nxt.kind = sfr_pkg::KIND_ARRAY;
                    s_nxt.src = sfr_pkg::SRC_ARRAY;
                    s_nxt.dummy = sfr_pkg::DUMMY_ONE;
                  end
                  sfr_pkg::OP_SLOW_READ, sfr_pkg::OP_LOWP_READ:
                  begin
                    s_nxt.kind = sfr_pkg::KIND_ARRAY;
                    s_nxt.src = sfr_pkg::SRC_ARRAY;
                    s_nxt.dummy = sfr_pkg::DUMMY_NONE;
                  end
                  sfr_pkg::OP_PAGE_READ:
                  begin
                    s_nxt.kind = sfr_pkg::KIND_PAGE;
                    s_nxt.src = sfr_pkg::SRC_ARRAY;
                    s_nxt.dummy = sfr_pkg::DUMMY_FOUR;
                  end
                  sfr_pkg::OP_BUF1_FAST, sfr_pkg::OP_BUF2_FAST:
                  begin
                    s_nxt.kind = sfr_pkg::KIND_BUFFER;
                    s_nxt.src = (full == sfr_pkg::OP_BUF1_FAST) ?
                      sfr_pkg::SRC_BUF1 : sfr_pkg::SRC_BUF2;
                    s_nxt.dummy = sfr_pkg::DUMMY_ONE;
                  end
                  sfr_pkg::OP_BUF1_SLOW, sfr_pkg::OP_BUF2_SLOW:
                  begin
                    s_nxt.kind = sfr_pkg::KIND_BUFFER;
                    s_nxt.src = (full == sfr_pkg::OP_BUF1_SLOW) ?
                      sfr_pkg::SRC_BUF1 : sfr_pkg::SRC_BUF2;
                    s_nxt.dummy = sfr_pkg::DUMMY_NONE;
                  end
                  default:
                  begin
                    // Foreign opcodes keep the output off until select rises
                    s_nxt.state = sfr_pkg::ST_IGNORE;
                  end
                endcase
              end
              else if (s_r.state == sfr_pkg::ST_ADDR)
              begin
                s_nxt.addr_hi = addr[15:0];
                if (s_r.byte_idx[1:0] == sfr_pkg::ADDR_LAST_BYTE)
                begin
                  // Present the first address now so data is ready early
                  s_nxt.page = start_page(s_r.p256, addr);
                  s_nxt.byte_pos = start_byte(s_r.p256, addr);
                  s_nxt.rd = 1'b1;
                  s_nxt.byte_idx = 3'h0;
                  s_nxt.out_cnt = 3'h0;
                  s_nxt.state = (s_r.dummy == sfr_pkg::DUMMY_NONE) ?
                    sfr_pkg::ST_DATA : sfr_pkg::ST_DUMMY;
                end
              end
              else if (s_r.byte_idx + 3'h1 == s_r.dummy)
              begin
                s_nxt.state = sfr_pkg::ST_DATA;
              end
            end
          end
        end
        sfr_pkg::ST_DATA:
        begin
          // Output changes on the falling clock so the host samples on rise
          if (sck_fall)
          begin
            s_nxt.oe = 1'b1;
            s_nxt.out_cnt = s_r.out_cnt - 3'h1;
            if (s_r.out_cnt == 3'h0)
            begin
              s_nxt.so = i_mem_data[7];
              s_nxt.shift_out = {i_mem_data[6:0], 1'b0};
              // Advance at once; eight clocks remain to fetch the next byte
              if (s_r.byte_pos != last_byte(s_r.p256))
              begin
                s_nxt.byte_pos = s_r.byte_pos + sfr_pkg::BYTE_STEP;
              end
              else
              begin
                s_nxt.byte_pos = 9'h000;
                if (s_r.kind == sfr_pkg::KIND_ARRAY)
                begin
                  // Page counter rolls over at the array end
                  s_nxt.page = s_r.page + sfr_pkg::PAGE_STEP;
                end
              end
            end
            else
            begin
              s_nxt.so = s_r.shift_out[7];
              s_nxt.shift_out = {s_r.shift_out[6:0], 1'b0};
            end
          end
        end
        sfr_pkg::ST_IGNORE:
        begin
          s_nxt.oe = 1'b0;
        end
        default:
        begin
          s_nxt.state = sfr_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge i_mclk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      s_r <= '0;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  // Outputs straight from flops
  assign o_so = s_r.so;
  assign o_so_oe = s_r.oe;
  assign o_mem_rd = s_r.rd;
  assign o_mem_src = s_r.src;
  assign o_mem_page = s_r.page;
  assign o_mem_byte = s_r.byte_pos;

endmodule

// file: verif/sfr_read_ctrl_sva.sv
`timescale 1ns/1ps
module sfr_read_ctrl_sva
(
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_reset_n,
  // Serial pins
  input wire logic i_cs_n,
  input wire logic i_sck,
  input wire logic o_so,
  input wire logic o_so_oe,
  // Storage port
  input wire logic o_mem_rd,
  input wire sfr_pkg::sfr_src_t o_mem_src,
  input wire logic [14:0] o_mem_page,
  input wire logic [8:0] o_mem_byte
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_reset_n);
  logic sck_d_r;
  logic [2:0] age_r;
  // Age of the last clock fall; output bits may only move shortly after one
  always_ff @(posedge i_mclk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      sck_d_r <= 1'b0;
      age_r <= 3'h7;
    end
    else
    begin
      sck_d_r <= i_sck;
      if (sck_d_r && !i_sck)
        age_r <= 3'h1;
      else if (age_r != 3'h7)
        age_r <= age_r + 3'h1;
    end
  end
  chk_oe_off_idle: assert property (i_cs_n [*5] |-> !o_so_oe)
    else $error("output enabled while deselected");
  chk_rd_off_idle: assert property (i_cs_n [*5] |-> !o_mem_rd)
    else $error("storage read while deselected");
  chk_so_quiet: assert property (!o_so_oe |-> !o_so)
    else $error("output not low while disabled");
  chk_so_bit_timing: assert property ((o_so_oe && $past(o_so_oe) && $changed(o_so))
    |-> age_r inside {[1:6]}) else $error("output bit moved away from a clock fall");
  chk_oe_after_rd: assert property ($rose(o_so_oe) |-> o_mem_rd)
    else $error("output enabled before an address");
  chk_byte_range: assert property (o_mem_rd |-> o_mem_byte <= sfr_pkg::LAST_BYTE_264)
    else $error("byte index past page end");
  chk_byte_step: assert property ((o_mem_rd && $past(o_mem_rd) && $changed(o_mem_byte))
    |-> (o_mem_byte == $past(o_mem_byte) + 9'h001 || o_mem_byte == 9'h000))
    else $error("byte index jumped");
  chk_page_step: assert property (o_mem_rd && $past(o_mem_rd)
    && $changed(o_mem_page)
    |-> (o_mem_byte == 9'h000 && o_mem_page == $past(o_mem_page) + 15'h0001))
    else $error("page changed without a page crossing");
  chk_src_hold: assert property ((o_mem_rd && $past(o_mem_rd)) |-> $stable(o_mem_src))
    else $error("source changed during a read");
endmodule
bind sfr_read_ctrl sfr_read_ctrl_sva chk_u (.i_mclk(i_mclk), .i_reset_n(i_reset_n),
  .i_cs_n(i_cs_n), .i_sck(i_sck), .o_so(o_so), .o_so_oe(o_so_oe), .o_mem_rd(o_mem_rd),
  .o_mem_src(o_mem_src), .o_mem_page(o_mem_page), .o_mem_byte(o_mem_byte));

// file: verif/sfr_mem_model.sv
`timescale 1ns/1ps
module sfr_mem_model
(
  // Clock
  input wire logic i_mclk,
  // Storage read port
  input wire logic i_rd,
  input wire sfr_pkg::sfr_src_t i_src,
  input wire logic [14:0] i_page,
  input wire logic [8:0] i_byte,
  output logic [7:0] o_data = 8'h00
);
  // Each store has its own pattern; the page only counts for the array
  always @(posedge i_mclk)
    if (i_rd)
      o_data <= i_byte[7:0] ^ {i_src, 6'h00} ^ (i_src == sfr_pkg::SRC_ARRAY ?
        {i_page[3:0], 4'h0} : 8'h00);
    else
      o_data <= ~o_data; // Idle port toggles so stale data never matches
endmodule

// file: verif/test_serial_flash_read_commands.sv
`timescale 1ns/1ps
module test_serial_flash_read_commands;
  logic i_mclk = 1'b0;
  logic i_reset_n = 1'b0;
  logic i_cs_n = 1'b1;
  logic i_sck = 1'b0;
  logic i_si = 1'b0;
  logic i_page_256 = 1'b0;
  logic o_so, o_so_oe, o_mem_rd, p256, e_same;
  sfr_pkg::sfr_src_t o_mem_src, e_src;
  logic [14:0] o_mem_page, e_page;
  logic [8:0] o_mem_byte, e_byte;
  logic [7:0] i_mem_data;
  logic [23:0] e_addr;
  int bad_count = 0;
  int checks = 0;
  int cycles = 0;
  // Device and its storage
  sfr_read_ctrl dut_u (.i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_cs_n(i_cs_n), .i_sck(i_sck),
    .i_si(i_si), .o_so(o_so), .o_so_oe(o_so_oe), .i_page_256(i_page_256), .o_mem_rd(o_mem_rd),
    .o_mem_src(o_mem_src), .o_mem_page(o_mem_page), .o_mem_byte(o_mem_byte),
    .i_mem_data(i_mem_data));
  sfr_mem_model mem_u (.i_mclk(i_mclk), .i_rd(o_mem_rd), .i_src(o_mem_src),
    .i_page(o_mem_page), .i_byte(o_mem_byte), .o_data(i_mem_data));
  always #25 i_mclk = ~i_mclk;
  // Hang guard: all scenarios need well under this many cycles
  always @(posedge i_mclk)
  begin
    cycles = cycles + 1;
    if (cycles == 30000)
    begin
      bad_count = bad_count + 1;
      finish_test();
    end
  end
  task automatic finish_test();
    if (bad_count == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge i_mclk);
  endtask
  // One byte each way, MSB first; read bit taken late in the high phase
  // A 400 ns link clock sits below every read limit, so any opcode is legal
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--)
    begin
      i_sck = 1'b0;
      i_si = tx[i];
      cyc(4);
      i_sck = 1'b1;
      cyc(4);
      rx[i] = o_so;
    end
  endtask
  task automatic start(input logic [7:0] op, input logic [23:0] a, input int nd);
    logic [7:0] rx;
    i_cs_n = 1'b0;
    cyc(4);
    xfer(op, rx);
    xfer(a[23:16], rx);
    xfer(a[15:8], rx);
    xfer(a[7:0], rx);
    repeat (nd) xfer(8'hA5, rx);
  endtask
  task automatic stop();
    i_sck = 1'b0;
    cyc(4);
    i_cs_n = 1'b1;
    cyc(8);
    chk({8'h00, o_so_oe}, 9'h000);
    chk({8'h00, o_mem_rd}, 9'h000);
  endtask
  task automatic plan(input logic m, input sfr_pkg::sfr_src_t s, input logic [23:0] a,
    input logic same);
    i_page_256 = m;
    p256 = m;
    e_src = s;
    e_same = same;
    e_addr = a;
    e_page = m ? a[22:8] : a[23:9];
    e_byte = m ? {1'b0, a[7:0]} : a[8:0];
    cyc(4);
  endtask
  // Reads n bytes and walks the expected address with the command's wrap
  task automatic get(input int n);
    logic [7:0] rx, ex;
    repeat (n)
    begin
      ex = e_byte[7:0] ^ {e_src, 6'h00};
      if (e_src == sfr_pkg::SRC_ARRAY)
        ex = ex ^ {e_page[3:0], 4'h0};
      xfer(8'h00, rx);
      chk({1'b0, rx}, {1'b0, ex});
      chk({8'h00, o_so_oe}, 9'h001);
      if (e_byte == (p256 ? 9'h0FF : 9'h107))
      begin
        e_byte = 9'h000;
        if (!e_same)
          e_page = e_page + 15'h0001;
      end
      else
        e_byte = e_byte + 9'h001;
    end
  endtask
  task automatic run(input logic [7:0] op, input int nd, input int n);
    start(op, e_addr, nd);
    get(n);
    stop();
  endtask
  task automatic t_fast();
    plan(1'b0, sfr_pkg::SRC_ARRAY, {15'h7FFF, 9'h106}, 1'b0);
    run(sfr_pkg::OP_FAST_READ, 1, 3);
    plan(1'b0, sfr_pkg::SRC_ARRAY, {15'h0003, 9'h107}, 1'b0);
    run(sfr_pkg::OP_FAST_READ, 1, 2);
  endtask
  task automatic t_slow_lowp();
    plan(1'b1, sfr_pkg::SRC_ARRAY, 24'h8012FE, 1'b0);
    run(sfr_pkg::OP_SLOW_READ, 0, 3);
    plan(1'b0, sfr_pkg::SRC_ARRAY, {15'h0005, 9'h000}, 1'b0);
    run(sfr_pkg::OP_LOWP_READ, 0, 2);
  endtask
  task automatic t_strap();
    plan(1'b1, sfr_pkg::SRC_ARRAY, 24'h0021FF, 1'b0);
    start(sfr_pkg::OP_FAST_READ, e_addr, 1);
    i_page_256 = 1'b0;
    get(2);
    stop();
  endtask
  task automatic t_page();
    plan(1'b1, sfr_pkg::SRC_ARRAY, 24'h7FFFFF, 1'b1);
    run(sfr_pkg::OP_PAGE_READ, 4, 2);
  endtask
  task automatic t_buf();
    logic [7:0] ops [4] = '{sfr_pkg::OP_BUF1_FAST, sfr_pkg::OP_BUF1_SLOW,
      sfr_pkg::OP_BUF2_FAST, sfr_pkg::OP_BUF2_SLOW};
    for (int i = 0; i < 4; i++)
    begin
      plan(i[0], i < 2 ? sfr_pkg::SRC_BUF1 : sfr_pkg::SRC_BUF2,
        i[0] ? 24'hFFFFFF : 24'h5A5B07, 1'b1);
      run(ops[i], i[0] ? 0 : 1, 2);
    end
  endtask
  // Abort mid-byte, then an opcode outside the read set stays silent
  task automatic t_abort();
    logic [7:0] rx;
    plan(1'b0, sfr_pkg::SRC_ARRAY, 24'h000010, 1'b0);
    start(sfr_pkg::OP_FAST_READ, e_addr, 1);
    get(1);
    i_sck = 1'b0;
    cyc(4);
    i_sck = 1'b1;
    cyc(4);
    stop();
    start(8'h55, e_addr, 0);
    repeat (2)
    begin
      xfer(8'h00, rx);
      chk({1'b0, rx}, 9'h000);
      chk({8'h00, o_so_oe}, 9'h000);
    end
    stop();
  endtask
  initial
  begin
    cyc(4);
    i_reset_n = 1'b1;
    cyc(4);
    t_fast();
    t_slow_lowp();
    t_strap();
    t_page();
    t_buf();
    t_abort();
    finish_test();
  end
endmodule
